// *** rtl/ppr_pkg.sv ***
package ppr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KP = 8'h04;
    localparam logic [7:0] OFS_TI = 8'h08;
    localparam logic [7:0] OFS_TD = 8'h0C;
    localparam logic [7:0] OFS_KF = 8'h10;
    localparam logic [7:0] OFS_HI = 8'h14;
    localparam logic [7:0] OFS_LO = 8'h18;
    localparam logic [7:0] OFS_OSC = 8'h1C;
    localparam logic [7:0] OFS_KP2 = 8'h20;
    localparam logic [7:0] OFS_KPS = 8'h24;
    localparam logic [7:0] OFS_RSW = 8'h28;
    localparam logic [7:0] OFS_STAT = 8'h2C;
    localparam logic [7:0] OFS_FREQ = 8'h30;
    // control register field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_INV_BIT = 1;
    localparam int CTRL_REF_LSB = 2;
    localparam int CTRL_FB_LSB = 4;
    localparam int CTRL_RMODE_BIT = 6;
    localparam int CTRL_TSC_LSB = 7;
    // reset values
    localparam logic RST_EN = 1'b0;
    localparam logic RST_INV = 1'b0;
    localparam logic [1:0] RST_REF = 2'h0;
    localparam logic [1:0] RST_FB = 2'h0;
    localparam logic RST_RMODE = 1'b0;
    localparam logic [1:0] RST_TSC = 2'h1;
    localparam logic [15:0] RST_KP = 16'h000A;
    localparam logic [15:0] RST_TI = 16'h0064;
    localparam logic [15:0] RST_TD = 16'h0000;
    localparam logic [15:0] RST_KF = 16'h0000;
    localparam logic [15:0] RST_HI = 16'h1770;
    localparam logic [15:0] RST_LO = 16'h0000;
    localparam logic [15:0] RST_OSC = 16'h03E8;
    localparam logic [15:0] RST_KP2 = 16'h03E8;
    localparam logic [15:0] RST_KPS = 16'h03E8;
    localparam logic [15:0] RST_RSW = 16'h0000;
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = (CLK_HZ / 1000000) * TICK_US;
    // arithmetic scales
    localparam logic signed [63:0] PERMILLE = 64'sh3E8;
    localparam logic signed [63:0] FULL_SCALE = 64'sh2710;
    localparam logic signed [63:0] TD_PER_TICK = 64'shA;
    localparam logic signed [47:0] TI_TO_TICKS = 48'sh64;
    localparam logic signed [47:0] ACC_SPAN = 48'sh2710;
    localparam logic signed [31:0] LOOP_SAT = 32'sh4E20;
    localparam logic [15:0] UNITY_PERMILLE = 16'h03E8;
    // ramp codes
    localparam logic [3:0] RAMP_PRI = 4'h0;
    localparam logic [3:0] RAMP_ALT = 4'h8;
    localparam logic [6:0] UNIT_FINE = 7'h01;
    localparam logic [6:0] UNIT_MID = 7'h0A;
    localparam logic [6:0] UNIT_COARSE = 7'h64;
    typedef enum logic [1:0] {REF_NONE = 2'b00, REF_CURRENT = 2'b01,
                              REF_VOLT1 = 2'b10, REF_VOLT2 = 2'b11} ppr_ref_type;
    typedef enum logic [1:0] {FB_CURRENT = 2'b00, FB_VOLT1 = 2'b01,
                              FB_VOLT2 = 2'b10} ppr_fb_type;
endpackage

// *** rtl/ppr_pid_ramp.sv ***
`timescale 1ns/1ps
module ppr_pid_ramp
    import ppr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // analog values, 0.01 percent units
    input wire logic [15:0] current_feedback_in,
    input wire logic [15:0] voltage_feedback_one_in,
    input wire logic [15:0] voltage_feedback_two_in,
    // frequencies, 0.01 hz units
    input wire logic [15:0] cmd_freq_in,
    input wire logic [15:0] max_freq_in,
    // multifunction inputs
    input wire logic loop_bypass_in,
    input wire logic integrator_clear_input_in,
    input wire logic alternate_gain_select_in,
    input wire logic ramp_step_select_low_in,
    input wire logic ramp_step_select_mid_in,
    input wire logic ramp_step_select_high_in,
    // results
    output logic [15:0] freq_out,
    output logic [31:0] loop_value_out,
    output logic loop_active_out,
    output logic [3:0] ramp_select_out,
    output logic [15:0] ramp_span_out,
    output logic [6:0] ramp_unit_out
);

    typedef struct packed {
        logic en;
        logic inv;
        logic [1:0] ref_sel;
        logic [1:0] fb_sel;
        logic rmode;
        logic [1:0] tsc;
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] td;
        logic [15:0] kf;
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] osc;
        logic [15:0] kp2;
        logic [15:0] kps;
        logic [15:0] rsw;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [15:0] tick_cnt;
        logic signed [31:0] e_prev;
        logic signed [47:0] acc;
        logic signed [31:0] loop_val;
        logic [15:0] freq;
        logic [3:0] ramp_sel;
        logic [15:0] span;
        logic [6:0] unit;
    } ppr_state_type;

    ppr_state_type st;
    ppr_state_type nx;

    logic tick_c;
    logic closed_c;
    logic acc_ok_c;
    logic [2:0] step_c;
    logic [15:0] ref_c;
    logic [15:0] fb_c;
    logic [15:0] kp_sel_c;
    logic [31:0] kp_eff_c;
    logic signed [31:0] err_c;
    logic signed [31:0] p_c;
    logic signed [31:0] i_c;
    logic signed [31:0] d_c;
    logic signed [31:0] f_c;
    logic signed [31:0] sum_c;
    logic signed [31:0] out_c;
    logic signed [31:0] corr_c;
    logic signed [31:0] freq_c;
    logic signed [47:0] acc_c;
    logic signed [47:0] ti_div_c;
    logic signed [47:0] cap_c;
    logic [31:0] rd_c;

    always_comb
    begin
        nx = st;
        tick_c = (st.tick_cnt == 16'h0000);
        closed_c = st.en && !loop_bypass_in;
        step_c = {ramp_step_select_high_in, ramp_step_select_mid_in, ramp_step_select_low_in};
        // write data phase lands one cycle after its address phase
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                OFS_CTRL:
                begin
                    nx.en = hwdata_in[CTRL_EN_BIT];
                    nx.inv = hwdata_in[CTRL_INV_BIT];
                    nx.ref_sel = hwdata_in[CTRL_REF_LSB +: 2];
                    nx.fb_sel = hwdata_in[CTRL_FB_LSB +: 2];
                    nx.rmode = hwdata_in[CTRL_RMODE_BIT];
                    nx.tsc = hwdata_in[CTRL_TSC_LSB +: 2];
                end
                OFS_KP: nx.kp = hwdata_in[15:0];
                OFS_TI: nx.ti = hwdata_in[15:0];
                OFS_TD: nx.td = hwdata_in[15:0];
                OFS_KF: nx.kf = hwdata_in[15:0];
                OFS_HI: nx.hi = hwdata_in[15:0];
                OFS_LO: nx.lo = hwdata_in[15:0];
                OFS_OSC: nx.osc = hwdata_in[15:0];
                OFS_KP2: nx.kp2 = hwdata_in[15:0];
                OFS_KPS: nx.kps = hwdata_in[15:0];
                OFS_RSW: nx.rsw = hwdata_in[15:0];
                default: nx.rsw = st.rsw;
            endcase
        end
        // only whole-word writes are taken
        nx.wr_pend = hsel_in && htrans_in[1] && hready_in && hwrite_in && (hsize_in == 3'b010);
        nx.wr_addr = haddr_in[7:0];
        // read sees a write still in its data phase, so back to back is coherent
        case (haddr_in[7:0])
            OFS_CTRL: rd_c = {23'h0, nx.tsc, nx.rmode, nx.fb_sel, nx.ref_sel, nx.inv, nx.en};
            OFS_KP: rd_c = {16'h0, nx.kp};
            OFS_TI: rd_c = {16'h0, nx.ti};
            OFS_TD: rd_c = {16'h0, nx.td};
            OFS_KF: rd_c = {16'h0, nx.kf};
            OFS_HI: rd_c = {16'h0, nx.hi};
            OFS_LO: rd_c = {16'h0, nx.lo};
            OFS_OSC: rd_c = {16'h0, nx.osc};
            OFS_KP2: rd_c = {16'h0, nx.kp2};
            OFS_KPS: rd_c = {16'h0, nx.kps};
            OFS_RSW: rd_c = {16'h0, nx.rsw};
            OFS_STAT: rd_c = st.loop_val;
            OFS_FREQ: rd_c = {st.ramp_sel, 12'h000, st.freq};
            default: rd_c = 32'h0000_0000;
        endcase
        if (hsel_in && htrans_in[1] && hready_in && !hwrite_in)
        begin
            nx.rdata = rd_c;
        end
        // control tick divider
        nx.tick_cnt = tick_c ? 16'(TICK_CYCLES - 1) : st.tick_cnt - 16'h0001;
        case (st.ref_sel)
            REF_CURRENT: ref_c = current_feedback_in;
            REF_VOLT1: ref_c = voltage_feedback_one_in;
            REF_VOLT2: ref_c = voltage_feedback_two_in;
            default: ref_c = 16'h0000;
        endcase
        case (st.fb_sel)
            FB_VOLT1: fb_c = voltage_feedback_one_in;
            FB_VOLT2: fb_c = voltage_feedback_two_in;
            default: fb_c = current_feedback_in;
        endcase
        err_c = $signed({16'h0000, ref_c}) - $signed({16'h0000, fb_c});
        kp_sel_c = alternate_gain_select_in ? st.kp2 : st.kp;
        kp_eff_c = ({16'h0000, kp_sel_c} * {16'h0000, st.kps}) / 32'h0000_03E8;
        p_c = 32'($signed(64'(err_c)) * $signed({32'h0, kp_eff_c}) / PERMILLE);
        // integrator stops once its own term reaches full scale, avoiding windup
        ti_div_c = $signed({32'h0, st.ti}) * TI_TO_TICKS;
        cap_c = ti_div_c * ACC_SPAN;
        acc_c = st.acc + 48'(err_c);
        acc_ok_c = (acc_c <= cap_c) && (acc_c >= -cap_c);
        if (integrator_clear_input_in || st.ti == 16'h0000)
        begin
            nx.acc = 48'sh0;
        end
        else if (tick_c && closed_c && acc_ok_c)
        begin
            nx.acc = acc_c;
        end
        if (st.ti == 16'h0000)
        begin
            ti_div_c = 48'sh1;
        end
        i_c = 32'(nx.acc / ti_div_c);
        // one tick stands for 1 ms; td counts 0.1 ms
        d_c = 32'($signed(64'(err_c - st.e_prev)) * $signed({48'h0, st.td}) / TD_PER_TICK);
        f_c = 32'($signed({48'h0, ref_c}) * $signed({48'h0, st.kf}) / PERMILLE);
        sum_c = p_c + i_c + d_c + f_c;
        if (st.inv)
        begin
            sum_c = -sum_c;
        end
        out_c = 32'($signed(64'(sum_c)) * $signed({48'h0, st.osc}) / PERMILLE);
        if (out_c > LOOP_SAT)
        begin
            out_c = LOOP_SAT;
        end
        else if (out_c < -LOOP_SAT)
        begin
            out_c = -LOOP_SAT;
        end
        if (tick_c)
        begin
            nx.e_prev = err_c;
        end
        if (!closed_c)
        begin
            nx.loop_val = 32'sh0;
        end
        else if (tick_c)
        begin
            nx.loop_val = out_c;
        end
        // loop value is in 0.01 percent units of the maximum frequency
        corr_c = 32'($signed(64'(st.loop_val)) * $signed({48'h0, max_freq_in}) / FULL_SCALE);
        freq_c = $signed({16'h0000, cmd_freq_in}) + corr_c;
        if (closed_c)
        begin
            if (freq_c > $signed({16'h0000, st.hi}))
            begin
                freq_c = $signed({16'h0000, st.hi});
            end
            else if (freq_c < $signed({16'h0000, st.lo}))
            begin
                freq_c = $signed({16'h0000, st.lo});
            end
        end
        else
        begin
            freq_c = $signed({16'h0000, cmd_freq_in});
        end
        nx.freq = freq_c[15:0];
        // step selection outranks the change frequency; zero disables the switch
        if (step_c != 3'b000)
        begin
            nx.ramp_sel = {1'b0, step_c};
        end
        else if (st.rsw != 16'h0000 && st.freq > st.rsw)
        begin
            nx.ramp_sel = RAMP_ALT;
        end
        else
        begin
            nx.ramp_sel = RAMP_PRI;
        end
        if (!st.rmode)
        begin
            nx.span = max_freq_in;
        end
        else
        begin
            nx.span = (nx.freq > st.freq) ? nx.freq - st.freq : st.freq - nx.freq;
        end
        case (st.tsc)
            2'b00: nx.unit = UNIT_FINE;
            2'b10: nx.unit = UNIT_COARSE;
            default: nx.unit = UNIT_MID;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st <= '{en: RST_EN, inv: RST_INV, ref_sel: RST_REF, fb_sel: RST_FB,
                    rmode: RST_RMODE, tsc: RST_TSC, kp: RST_KP, ti: RST_TI, td: RST_TD,
                    kf: RST_KF, hi: RST_HI, lo: RST_LO, osc: RST_OSC, kp2: RST_KP2,
                    kps: RST_KPS, rsw: RST_RSW, unit: UNIT_MID, default: '0};
        end
        else
        begin
            st <= nx;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st.rdata;
    assign freq_out = st.freq;
    assign loop_value_out = st.loop_val;
    assign loop_active_out = st.en;
    assign ramp_select_out = st.ramp_sel;
    assign ramp_span_out = st.span;
    assign ramp_unit_out = st.unit;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence bypass_s;
        loop_bypass_in && st.en;
    endsequence

    sequence integ_s;
        tick_c && closed_c && !integrator_clear_input_in && st.ti != 16'h0000 && acc_ok_c;
    endsequence

    sequence kp2_write_s;
        hsel_in && htrans_in[1] && hready_in && hwrite_in && hsize_in == 3'b010
            && haddr_in[7:0] == OFS_KP2;
    endsequence

    sequence p_only_s;
        tick_c && closed_c && st.ti == 16'h0000 && st.td == 16'h0000 && st.kf == 16'h0000
            && !st.inv && st.osc == UNITY_PERMILLE && st.kps == UNITY_PERMILLE
            && !alternate_gain_select_in && st.kp == UNITY_PERMILLE;
    endsequence

    loop_off_cmd_a: assert property (!st.en |=> st.freq == $past(cmd_freq_in))
        else $error("disabled loop altered frequency");
    bypass_zero_a: assert property (bypass_s |=> (st.loop_val == 0) && (st.freq == $past(cmd_freq_in)))
        else $error("bypass did not force manual output");
    p_only_a: assert property (p_only_s |=> st.loop_val == $past(err_c))
        else $error("unity proportional output differs from error");
    integ_step_a: assert property (integ_s |=> st.acc == $past(st.acc) + 48'($past(err_c)))
        else $error("integrator did not accumulate error on tick");
    clamp_high_a: assert property (closed_c |=> st.freq <= $past(st.hi))
        else $error("closed loop frequency above upper bound");
    clamp_low_a: assert property ((closed_c && st.lo <= st.hi) |=> st.freq >= $past(st.lo))
        else $error("closed loop frequency below lower bound");
    iclear_zero_a: assert property (integrator_clear_input_in |=> st.acc == 48'sh0)
        else $error("integrator clear did not zero accumulator");
    alt_gain_write_a: assert property (kp2_write_s |-> ##2 st.kp2 == $past(hwdata_in[15:0]))
        else $error("alternate gain write not stored");
    step_prio_a: assert property ((step_c != 3'b000) |=> st.ramp_sel == {1'b0, $past(step_c)})
        else $error("step ramp selection lost priority");
    span_full_a: assert property (!st.rmode |=> st.span == $past(max_freq_in))
        else $error("full span mode wrong");
    unit_fine_a: assert property ((st.tsc == 2'b00) |=> st.unit == UNIT_FINE)
        else $error("resolution code zero wrong unit");
    tick_period_a: assert property (tick_c |=> !tick_c [*2])
        else $error("control tick repeats too soon");
    // a zero integral time also parks the accumulator
    ti_zero_acc_a: assert property ((st.ti == 16'h0000) |=> st.acc == 48'sh0)
        else $error("accumulator not parked with zero integral time");
    loop_off_zero_a: assert property (!st.en |=> st.loop_val == 32'sh0)
        else $error("disabled loop kept a loop value");
    unit_coarse_a: assert property ((st.tsc == 2'b10) |=> st.unit == UNIT_COARSE)
        else $error("resolution code two wrong unit");
    ramp_above_a: assert property ((step_c == 3'b000 && st.rsw != 16'h0000 && st.freq > st.rsw)
        |=> st.ramp_sel == RAMP_ALT)
        else $error("alternate ramp not chosen above change frequency");

endmodule // ppr_pid_ramp

// *** sim/ppr_field_model.sv ***
`timescale 1ns/1ps
module ppr_field_model
(
    // clock
    input wire logic clk_in,
    // transmitters, 0.01 percent units
    output logic [15:0] current_out,
    output logic [15:0] volt_one_out,
    output logic [15:0] volt_two_out,
    // terminal contacts
    output logic bypass_out,
    output logic clear_out,
    output logic alt_gain_out,
    output logic [2:0] step_out
);
    initial
    begin
        current_out = 16'h0000;
        volt_one_out = 16'h0000;
        volt_two_out = 16'h0000;
        bypass_out = 1'b0;
        clear_out = 1'b0;
        alt_gain_out = 1'b0;
        step_out = 3'h0;
    end
    // values move only just after an edge, so no sample lands mid-change
    task automatic analog(input logic [15:0] cur, input logic [15:0] v1, input logic [15:0] v2);
        @(posedge clk_in);
        current_out <= cur;
        volt_one_out <= v1;
        volt_two_out <= v2;
    endtask
    // contacts are clean levels; bounce is not modelled
    task automatic contacts(input logic byp, input logic clr, input logic alt, input logic [2:0] stp);
        @(posedge clk_in);
        bypass_out <= byp;
        clear_out <= clr;
        alt_gain_out <= alt;
        step_out <= stp;
    endtask
endmodule // ppr_field_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
    import ppr_pkg::*;
    localparam int TICKS = 8;
    localparam int LIMIT = 20000;
    logic clk_in, reset_in, hsel, hwrite, hreadyout, hresp, byp, clr, alt, loop_act;
    logic [1:0] htrans;
    logic [2:0] hsize, stp;
    logic [31:0] haddr, hwdata, hrdata, loop_val;
    logic [15:0] cur, v1, v2, cmd_freq, max_freq, freq, rspan;
    logic [3:0] rsel;
    logic [6:0] runit;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    ppr_field_model i_field (.clk_in(clk_in), .current_out(cur), .volt_one_out(v1),
        .volt_two_out(v2), .bypass_out(byp), .clear_out(clr), .alt_gain_out(alt),
        .step_out(stp));

    ppr_pid_ramp #(.TICK_CYCLES(TICKS)) i_dut (.clk_in(clk_in), .reset_in(reset_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
        .current_feedback_in(cur), .voltage_feedback_one_in(v1),
        .voltage_feedback_two_in(v2), .cmd_freq_in(cmd_freq), .max_freq_in(max_freq),
        .loop_bypass_in(byp), .integrator_clear_input_in(clr),
        .alternate_gain_select_in(alt), .ramp_step_select_low_in(stp[0]),
        .ramp_step_select_mid_in(stp[1]), .ramp_step_select_high_in(stp[2]),
        .freq_out(freq), .loop_value_out(loop_val), .loop_active_out(loop_act),
        .ramp_select_out(rsel), .ramp_span_out(rspan), .ramp_unit_out(runit));

    task automatic close_out;
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // called just after an edge; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rdat);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge clk_in);
        while (hreadyout !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_in);
        while (hreadyout !== 1'b1) @(posedge clk_in);
        rdat = hrdata;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
        logic [31:0] dummy;
        bus(1'b1, ofs, data, dummy);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, ofs, 32'h0, got);
        chk(what, exp, got);
    endtask

    function automatic logic [31:0] ctl(input logic en, input logic inv, input logic [1:0] rs,
                                        input logic [1:0] fb, input logic rm, input logic [1:0] ts);
        return {23'h0, ts, rm, fb, rs, inv, en};
    endfunction

    // three ticks so a fresh loop value has surely been loaded
    task automatic chk_out(input logic [31:0] lexp, input logic [15:0] fexp);
        repeat (3 * TICKS + 4) @(posedge clk_in);
        chk("loop_value_out", lexp, loop_val);
        chk("freq_out", {16'h0, fexp}, {16'h0, freq});
    endtask

    task automatic t_reset;
        logic [7:0] ofs [12] = '{OFS_CTRL, OFS_KP, OFS_TI, OFS_TD, OFS_KF, OFS_HI, OFS_LO,
                                 OFS_OSC, OFS_KP2, OFS_KPS, OFS_RSW, 8'h40};
        logic [31:0] exp [12] = '{32'h80, 32'h0A, 32'h64, 32'h0, 32'h0, 32'h1770, 32'h0,
                                  32'h3E8, 32'h3E8, 32'h3E8, 32'h0, 32'h0};
        for (int i = 0; i < 12; i++)
            rd_chk("reset register", ofs[i], exp[i]);
        chk("ramp_unit_out", 32'h0A, {25'h0, runit});
        chk("hresp_out", 32'h0, {31'h0, hresp});
    endtask

    task automatic t_disabled;
        i_field.analog(16'h2710, 16'h0000, 16'h0000);
        cmd_freq <= 16'h1B58;
        chk_out(32'h0, 16'h1B58);
        chk("loop_active_out", 32'h0, {31'h0, loop_act});
        cmd_freq <= 16'h03E8;
    endtask

    task automatic t_prop;
        wr(OFS_TI, 32'h0);
        wr(OFS_KP, 32'h1F4);
        // derivative left at zero, only ever beside p or pi
        wr(OFS_CTRL, ctl(1, 0, 2'h1, 2'h1, 0, 2'h1));
        chk_out(32'h1388, 16'h0FA0);
        chk("loop_active_out", 32'h1, {31'h0, loop_act});
        rd_chk("status", OFS_STAT, 32'h1388);
        i_field.contacts(0, 0, 1, 3'h0);
        chk_out(32'h2710, 16'h1770);
        wr(OFS_KPS, 32'h1F4);
        chk_out(32'h1388, 16'h0FA0);
        wr(OFS_KPS, 32'h3E8);
        wr(OFS_KP2, 32'h1F4);
        chk_out(32'h1388, 16'h0FA0);
        wr(OFS_KP2, 32'h3E8);
        i_field.contacts(0, 0, 0, 3'h0);
    endtask

    task automatic t_inv_scale;
        wr(OFS_LO, 32'h7D0);
        wr(OFS_CTRL, ctl(1, 1, 2'h1, 2'h1, 0, 2'h1));
        chk_out(32'hFFFFEC78, 16'h07D0);
        wr(OFS_OSC, 32'h1F4);
        wr(OFS_CTRL, ctl(1, 0, 2'h1, 2'h1, 0, 2'h1));
        chk_out(32'h09C4, 16'h09C4);
        wr(OFS_OSC, 32'h3E8);
        wr(OFS_LO, 32'h0);
        i_field.contacts(1, 0, 0, 3'h0);
        chk_out(32'h0, 16'h03E8);
        i_field.contacts(0, 0, 0, 3'h0);
        chk_out(32'h1388, 16'h0FA0);
    endtask

    task automatic t_sources;
        logic [1:0] rs [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
        logic [1:0] fb [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
        logic [31:0] exp [6] = '{32'h0, 32'h3E8, 32'h7D0, 32'h3E8, 32'hFFFFF830, 32'hFFFFFC18};
        wr(OFS_KP, 32'h3E8);
        i_field.analog(16'h0BB8, 16'h07D0, 16'h03E8);
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_CTRL, ctl(1, 0, rs[i], fb[i], 0, 2'h1));
            repeat (3 * TICKS + 4) @(posedge clk_in);
            chk("loop source", exp[i], loop_val);
        end
        wr(OFS_KP, 32'h0);
        wr(OFS_KF, 32'h3E8);
        i_field.analog(16'h2710, 16'h2710, 16'h0);
        wr(OFS_CTRL, ctl(1, 0, 2'h1, 2'h1, 0, 2'h1));
        chk_out(32'h2710, 16'h1770);
        wr(OFS_KF, 32'h1F4);
        chk_out(32'h1388, 16'h0FA0);
        wr(OFS_KF, 32'h0);
    endtask

    // the kick lasts one tick, so the peak over two ticks is judged
    task automatic t_deriv;
        logic [31:0] peak;
        peak = 32'h0;
        wr(OFS_KP, 32'h3E8);
        wr(OFS_TD, 32'hA);
        i_field.analog(16'h2710, 16'h2328, 16'h0);
        repeat (2 * TICKS)
        begin
            @(posedge clk_in);
            if ($signed(loop_val) > $signed(peak))
                peak = loop_val;
        end
        chk("derivative kick", 32'h7D0, peak);
        chk_out(32'h3E8, 16'h0640);
        wr(OFS_TD, 32'h0);
        wr(OFS_KP, 32'h0);
    endtask

    // one tenth of a second of integral time is a hundred ticks to full scale
    task automatic t_integral;
        i_field.analog(16'h2710, 16'h0, 16'h0);
        wr(OFS_TI, 32'h1);
        repeat (50 * TICKS) @(posedge clk_in);
        chk("integral midway", 32'h1, {31'h0, ($signed(loop_val) > 3000 &&
            $signed(loop_val) < 7000)});
        repeat (70 * TICKS) @(posedge clk_in);
        chk("integral full", 32'h2710, loop_val);
        i_field.contacts(0, 1, 0, 3'h0);
        chk_out(32'h0, 16'h03E8);
        i_field.contacts(0, 0, 0, 3'h0);
        wr(OFS_TI, 32'h0);
    endtask

    task automatic t_ramp;
        logic [6:0] unit_exp [4] = '{7'h01, 7'h0A, 7'h64, 7'h0A};
        wr(OFS_CTRL, ctl(0, 0, 2'h1, 2'h1, 0, 2'h1));
        cmd_freq <= 16'h0FA0;
        for (int i = 1; i < 8; i++)
        begin
            i_field.contacts(0, 0, 0, i[2:0]);
            repeat (2) @(posedge clk_in);
            chk("ramp step", i, {28'h0, rsel});
        end
        i_field.contacts(0, 0, 0, 3'h3);
        wr(OFS_RSW, 32'h7D0);
        repeat (2) @(posedge clk_in);
        chk("ramp step priority", 32'h3, {28'h0, rsel});
        i_field.contacts(0, 0, 0, 3'h0);
        repeat (2) @(posedge clk_in);
        chk("ramp above switch", 32'h8, {28'h0, rsel});
        rd_chk("freq register", OFS_FREQ, 32'h8000_0FA0);
        wr(OFS_RSW, 32'h1388);
        repeat (2) @(posedge clk_in);
        chk("ramp below switch", 32'h0, {28'h0, rsel});
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CTRL, ctl(0, 0, 2'h1, 2'h1, 0, i[1:0]));
            repeat (2) @(posedge clk_in);
            chk("ramp unit", {25'h0, unit_exp[i]}, {25'h0, runit});
        end
        chk("ramp span full", 32'h1770, {16'h0, rspan});
        wr(OFS_CTRL, ctl(0, 0, 2'h1, 2'h1, 1, 2'h1));
        repeat (4) @(posedge clk_in);
        chk("ramp span delta", 32'h0, {16'h0, rspan});
        cmd_freq <= 16'h1388;
        @(posedge clk_in);
        @(negedge clk_in);
        chk("ramp span step", 32'h3E8, {16'h0, rspan});
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // hang guard, well above the some 1700 cycles the run needs
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            close_out();
        end
    end

    initial
    begin
        reset_in = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        cmd_freq = 16'h03E8;
        max_freq = 16'h1770;
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_disabled();
        t_prop();
        t_inv_scale();
        t_sources();
        t_deriv();
        t_integral();
        t_ramp();
        close_out();
    end
endmodule // tb
